// >>> pkg/cvl_regs.vh
`ifndef CVL_REGS_VH
`define CVL_REGS_VH

// Register offsets
`define CVL_ADDR_PH1_LIMIT 8'h05
`define CVL_ADDR_PH2_LIMIT 8'h07
`define CVL_ADDR_PH3_LIMIT 8'h09
`define CVL_ADDR_OUT0_VCODE 8'h0a
`define CVL_ADDR_OUT0_FLOOR 8'h0b

// Reset values
`define CVL_RST_PH_LIMIT 8'h3a
`define CVL_RST_OUT0_VCODE 8'h61
`define CVL_RST_OUT0_FLOOR 8'h00

// Current limit field position
`define CVL_ILIM_HI 5
`define CVL_ILIM_LO 3

// Current limit decode in mA
`define CVL_ILIM_BASE_MA 16'd1500
`define CVL_ILIM_STEP_MA 16'd500

// Voltage code segment boundaries
`define CVL_VSEG1_LAST 8'h17
`define CVL_VSEG2_FIRST 8'h18
`define CVL_VSEG2_LAST 8'h9d
`define CVL_VSEG3_FIRST 8'h9e

// Voltage decode in mV; middle segment in uV
`define CVL_VSEG1_BASE_MV 16'd500
`define CVL_VSEG1_STEP_MV 16'd10
`define CVL_VSEG2_BASE_UV 32'd735000
`define CVL_VSEG2_STEP_UV 32'd5000
`define CVL_VSEG3_BASE_MV 16'd1420
`define CVL_VSEG3_STEP_MV 16'd20
`define CVL_UV_PER_MV 32'd1000

`endif

// >>> rtl/cvl_limit_voltage_regs.v
`timescale 1ns/1ns
`include "cvl_regs.vh"
module cvl_limit_voltage_regs #(
   parameter ADDR_W = 8,
   parameter REG_W = 8,
   parameter SETPT_W = 16
) (
   input wire ref_clk,
   input wire rst_n,
   input wire clk_en,
   input wire reg_wr,
   input wire reg_rd,
   input wire [ADDR_W-1:0] reg_addr,
   input wire [REG_W-1:0] reg_wdata,
   output reg [REG_W-1:0] reg_rdata,
   output reg reg_addr_hit,
   input wire output0_pin_control_enable,
   input wire output0_pin_level_select,
   input wire output0_enable_pin,
   output reg [SETPT_W-1:0] phase1_limit_ma,
   output reg [SETPT_W-1:0] phase2_limit_ma,
   output reg [SETPT_W-1:0] phase3_limit_ma,
   output reg [REG_W-1:0] output0_target_code,
   output reg [SETPT_W-1:0] output0_target_mv,
   output reg output0_floor_active
);

   // Stored registers, one per mapped address
   reg [REG_W-1:0] phase1_limit_ctrl_reg;
   reg [REG_W-1:0] phase2_limit_ctrl_reg;
   reg [REG_W-1:0] phase3_limit_ctrl_reg;
   reg [REG_W-1:0] output0_voltage_code_reg;
   reg [REG_W-1:0] output0_floor_voltage_code_reg;
   // Read path next values
   reg [REG_W-1:0] rdata_next;
   reg hit_next;
   // Per-register write enables
   wire wr_ok;
   wire ph1_wr;
   wire ph2_wr;
   wire ph3_wr;
   wire vcode_wr;
   wire floor_wr;
   // Output 0 code selection
   wire floor_sel;
   wire [REG_W-1:0] code_sel;

   // Address match, shared by every write enable
   function addr_is;
      input [7:0] addr;
      input [7:0] target;
      begin
         addr_is = (addr == target);
      end
   endfunction

   // Limit field to milliamps
   function [15:0] cvl_ilim_ma;
      input [7:0] ctrl;
      begin
         cvl_ilim_ma = `CVL_ILIM_BASE_MA +
            `CVL_ILIM_STEP_MA * {13'h0000, ctrl[`CVL_ILIM_HI:`CVL_ILIM_LO]};
      end
   endfunction

   // Three-segment code to millivolts; middle segment works in microvolts, and its 5 mV steps
   // from 735 mV always land on whole mV, so the divide by 1000 drops no remainder
   function [15:0] cvl_vcode_mv;
      input [7:0] code;
      reg [31:0] uv;
      reg [31:0] mv_wide;
      begin
         uv = 32'h0;
         mv_wide = 32'h0;
         if (code <= `CVL_VSEG1_LAST) begin
            cvl_vcode_mv = `CVL_VSEG1_BASE_MV + `CVL_VSEG1_STEP_MV * {8'h00, code};
         end else if (code <= `CVL_VSEG2_LAST) begin
            uv = `CVL_VSEG2_BASE_UV +
               `CVL_VSEG2_STEP_UV * {24'h000000, code - `CVL_VSEG2_FIRST};
            mv_wide = uv / `CVL_UV_PER_MV;
            // Quotient stays well under 16 bits, so the cut loses nothing
            cvl_vcode_mv = mv_wide[15:0];
         end else begin
            cvl_vcode_mv = `CVL_VSEG3_BASE_MV +
               `CVL_VSEG3_STEP_MV * {8'h00, code - `CVL_VSEG3_FIRST};
         end
      end
   endfunction

   // Floor state only when the pin acts as roof/floor select and is low
   assign floor_sel = output0_pin_control_enable & output0_pin_level_select &
      ~output0_enable_pin;
   assign code_sel = floor_sel ? output0_floor_voltage_code_reg :
      output0_voltage_code_reg;

   // A write only counts when the clock enable lets the edge through
   assign wr_ok = clk_en & reg_wr;
   assign ph1_wr = wr_ok & addr_is(reg_addr, `CVL_ADDR_PH1_LIMIT);
   assign ph2_wr = wr_ok & addr_is(reg_addr, `CVL_ADDR_PH2_LIMIT);
   assign ph3_wr = wr_ok & addr_is(reg_addr, `CVL_ADDR_PH3_LIMIT);
   assign vcode_wr = wr_ok & addr_is(reg_addr, `CVL_ADDR_OUT0_VCODE);
   assign floor_wr = wr_ok & addr_is(reg_addr, `CVL_ADDR_OUT0_FLOOR);
   // Unmapped writes raise no enable and are simply dropped

   // Phase 1 limit byte; reserved bits kept as plain storage
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase1_limit_ctrl_reg <= `CVL_RST_PH_LIMIT;
      end else if (ph1_wr) begin
         phase1_limit_ctrl_reg <= reg_wdata;
      end
   end

   // Phase 2 limit byte
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase2_limit_ctrl_reg <= `CVL_RST_PH_LIMIT;
      end else if (ph2_wr) begin
         phase2_limit_ctrl_reg <= reg_wdata;
      end
   end

   // Phase 3 limit byte
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase3_limit_ctrl_reg <= `CVL_RST_PH_LIMIT;
      end else if (ph3_wr) begin
         phase3_limit_ctrl_reg <= reg_wdata;
      end
   end

   // Normal output 0 voltage code
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         output0_voltage_code_reg <= `CVL_RST_OUT0_VCODE;
      end else if (vcode_wr) begin
         output0_voltage_code_reg <= reg_wdata;
      end
   end

   // Floor output 0 voltage code
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         output0_floor_voltage_code_reg <= `CVL_RST_OUT0_FLOOR;
      end else if (floor_wr) begin
         output0_floor_voltage_code_reg <= reg_wdata;
      end
   end

   // Read mux; unmapped addresses read zero and flag no hit
   always @* begin
      rdata_next = 8'h00;
      hit_next = 1'b1;
      case (reg_addr)
         `CVL_ADDR_PH1_LIMIT: rdata_next = phase1_limit_ctrl_reg;
         `CVL_ADDR_PH2_LIMIT: rdata_next = phase2_limit_ctrl_reg;
         `CVL_ADDR_PH3_LIMIT: rdata_next = phase3_limit_ctrl_reg;
         `CVL_ADDR_OUT0_VCODE: rdata_next = output0_voltage_code_reg;
         `CVL_ADDR_OUT0_FLOOR: rdata_next = output0_floor_voltage_code_reg;
         default: hit_next = 1'b0;
      endcase
   end

   // Read data registered one cycle after the read strobe
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         reg_addr_hit <= 1'b0;
      end else if (clk_en && reg_rd) begin
         reg_rdata <= rdata_next;
         reg_addr_hit <= hit_next;
      end
   end

   // Limit set-points follow the registers on every clk_en cycle, so changes apply while running;
   // the cost is one cycle of latency after each write
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase1_limit_ma <= 16'h0000;
         phase2_limit_ma <= 16'h0000;
         phase3_limit_ma <= 16'h0000;
      end else if (clk_en) begin
         phase1_limit_ma <= cvl_ilim_ma(phase1_limit_ctrl_reg);
         phase2_limit_ma <= cvl_ilim_ma(phase2_limit_ctrl_reg);
         phase3_limit_ma <= cvl_ilim_ma(phase3_limit_ctrl_reg);
      end
   end

   // Output 0 target; code and millivolts are registered together, so they agree from the first clk_en edge (reset loads both with 0)
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         output0_target_code <= 8'h00;
         output0_target_mv <= 16'h0000;
         output0_floor_active <= 1'b0;
      end else if (clk_en) begin
         output0_target_code <= code_sel;
         output0_target_mv <= cvl_vcode_mv(code_sel);
         output0_floor_active <= floor_sel;
      end
   end

endmodule // cvl_limit_voltage_regs

// >>> verification/cvl_host_model.sv
`timescale 1ns/1ns
module cvl_host_model (
   input wire ref_clk,
   output reg reg_wr = 1'b0, reg_rd = 1'b0,
   output reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00
);
   // One byte per call, held across one rising edge
   task xfer(input bit w, input bit [7:0] a, d);
      @(negedge ref_clk);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = ~d; // Stale data must not linger
   endtask
endmodule // cvl_host_model

// >>> verification/cvl_limit_voltage_regs_props.sv
`timescale 1ns/1ns
module cvl_limit_voltage_regs_props (
   input wire ref_clk, rst_n, clk_en, reg_wr, reg_rd, reg_addr_hit, output0_floor_active,
   input wire output0_pin_control_enable, output0_pin_level_select, output0_enable_pin,
   input wire [7:0] reg_addr, reg_wdata, reg_rdata, output0_target_code,
   input wire [15:0] phase1_limit_ma, output0_target_mv
);
   reg seen_reg;
   wire [7:0] c = output0_target_code;
   wire [15:0] v = output0_target_mv;
   wire fl = output0_pin_control_enable & output0_pin_level_select & ~output0_enable_pin;
   wire hit = reg_addr inside {8'h05, 8'h07, 8'h09, 8'h0a, 8'h0b};
   // Set-points read 0 until the first enabled edge
   always @(posedge ref_clk or negedge rst_n)
      if (!rst_n) seen_reg <= 1'b0;
      else if (clk_en) seen_reg <= 1'b1;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_limit_decode: assert property (clk_en && reg_wr && reg_addr == 8'h05 ##1 clk_en
      |=> phase1_limit_ma == 16'd1500 + 16'd500 * $past(reg_wdata[5:3], 2)) else $error("limit");
   a_read_hit: assert property (clk_en && reg_rd
      |=> reg_addr_hit == $past(hit) && (reg_addr_hit || reg_rdata == 8'h00)) else $error("hit");
   a_floor_flag: assert property (clk_en |=> output0_floor_active == $past(fl))
      else $error("floor");
   a_normal_code: assert property (clk_en && reg_wr && reg_addr == 8'h0a ##1 clk_en && !fl
      |=> c == $past(reg_wdata, 2)) else $error("normal");
   a_floor_code: assert property (clk_en && reg_wr && reg_addr == 8'h0b ##1 clk_en && fl
      |=> c == $past(reg_wdata, 2)) else $error("floor code");
   a_seg_low: assert property (seen_reg && c <= 8'h17 |-> v == 16'd500 + 16'd10 * c)
      else $error("low");
   a_seg_mid: assert property (seen_reg && c >= 8'h18 && c <= 8'h9d
      |-> v == (32'd735000 + 32'd5000 * (c - 8'h18)) / 32'd1000) else $error("mid");
   a_seg_high: assert property (seen_reg && c >= 8'h9e |-> v == 16'd1420 + 16'd20 * (c - 8'h9e))
      else $error("high");
endmodule // cvl_limit_voltage_regs_props
bind cvl_limit_voltage_regs cvl_limit_voltage_regs_props props_u (.*);

// >>> verification/cvl_limit_voltage_regs_test.sv
`timescale 1ns/1ns
module cvl_limit_voltage_regs_test;
   logic ref_clk = 0, rst_n = 0, clk_en = 1;
   logic [2:0] pn = 0; // Pin control, roof/floor select, enable pin
   wire reg_wr, reg_rd, reg_addr_hit, fa;
   wire [7:0] reg_addr, reg_wdata, reg_rdata, tc;
   wire [15:0] l[3], mv;
   int errors = 0, check_count = 0, cyc = 0, seed = 32'hd89af5f1, i, k, d, m[int];
   int b[6] = '{'h00, 'h17, 'h18, 'h9d, 'h9e, 'hff};
   always #25 ref_clk = ~ref_clk;
   cvl_host_model host_u (.*);
   cvl_limit_voltage_regs dut_u (.ref_clk, .rst_n, .clk_en, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_addr_hit, .output0_pin_control_enable(pn[2]),
      .output0_pin_level_select(pn[1]), .output0_enable_pin(pn[0]), .phase1_limit_ma(l[0]),
      .phase2_limit_ma(l[1]), .phase3_limit_ma(l[2]), .output0_target_code(tc),
      .output0_target_mv(mv), .output0_floor_active(fa));
   function int mvf(int c);
      return c < 'h18 ? 500 + 10 * c : c < 'h9e ? (735000 + 5000 * (c - 'h18)) / 1000
         : 1420 + 20 * (c - 'h9e);
   endfunction
   task chk(input string n, input logic [15:0] s, e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task rd(input int a);
      host_u.xfer(0, a, 0);
      chk("rdata", reg_rdata, m.exists(a) ? m[a] : 0);
      chk("hit", reg_addr_hit, m.exists(a));
   endtask
   // The model only takes writes that the gated clock lets through
   task wr(input int a, v);
      host_u.xfer(1, a, v);
      if (clk_en && m.exists(a)) m[a] = v & 'hff;
   endtask
   task tally_and_finish;
      $display("errors=%0d check_count=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge ref_clk) if (++cyc > 3000) begin
      errors++;
      tally_and_finish;
   end
   initial begin
      m[5] = 'h3a; m[7] = 'h3a; m[9] = 'h3a; m['ha] = 'h61; m['hb] = 'h00;
      repeat (4) @(negedge ref_clk);
      rst_n = 1;
      foreach (m[a]) rd(a);
      rd('h06);
      // Every limit code on each phase, rewritten while running
      for (i = 0; i < 24; i++) begin
         k = 5 + 2 * (i % 3);
         wr(k, $random(seed) & 'hc7 | i / 3 << 3);
         rd(k);
         chk("limit", l[i % 3], 1500 + 500 * (i / 3));
      end
      // Segment edges first, then random codes and pin levels
      for (i = 0; i < 48; i++) begin
         d = i < 6 ? b[i] : $random(seed) & 'hff;
         pn = i < 6 ? 0 : $random(seed);
         wr('ha, d);
         wr('hb, ~d);
         @(negedge ref_clk);
         k = pn == 3'b110 ? m['hb] : m['ha];
         chk("code", tc, k);
         chk("mv", mv, mvf(k));
         chk("floor", fa, pn == 3'b110);
      end
      clk_en = 0;
      wr('ha, 'h55);
      clk_en = 1;
      rd('ha);
      tally_and_finish;
   end
endmodule // cvl_limit_voltage_regs_test
